// File: include/bus_watchdog_pkg.sv
/*
 * Package for the bus-activity watchdog: register layout, reset values,
 * period encodings and timing constants.
 * Assumes a 20 MHz core timebase.
 */
package bus_watchdog_pkg;

    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned FAN_COUNT         = 6;
    localparam int unsigned DUTY_W            = 8;

    // Register offset and field positions
    localparam logic [7:0]  GLOBAL_CONTROL_OFFSET = 8'h00;
    localparam int unsigned STATUS_BIT            = 0;
    localparam int unsigned PERIOD_LSB            = 1;
    localparam int unsigned PERIOD_MSB            = 2;

    // Period field encodings
    localparam logic [1:0]  PERIOD_OFF  = 2'h0;
    localparam logic [1:0]  PERIOD_5S   = 2'h1;
    localparam logic [1:0]  PERIOD_10S  = 2'h2;
    localparam logic [1:0]  PERIOD_30S  = 2'h3;

    localparam logic [1:0]  PERIOD_STRAP_LOW  = PERIOD_OFF;
    localparam logic [1:0]  PERIOD_STRAP_HIGH = PERIOD_30S;
    localparam logic        STATUS_RESET      = 1'b0;

    // Periods in seconds and their cycle counts
    localparam longint unsigned PERIOD_A_S = 5;
    localparam longint unsigned PERIOD_B_S = 10;
    localparam longint unsigned PERIOD_C_S = 30;
    localparam longint unsigned PERIOD_A_CYC = PERIOD_A_S * CLK_HZ;
    localparam longint unsigned PERIOD_B_CYC = PERIOD_B_S * CLK_HZ;
    localparam longint unsigned PERIOD_C_CYC = PERIOD_C_S * CLK_HZ;

    localparam int unsigned TIMER_W = 30;

    localparam logic [DUTY_W-1:0] FULL_DUTY = 8'hff;

    typedef logic [DUTY_W-1:0] duty_t;
    typedef duty_t [FAN_COUNT-1:0] fan_duty_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } reg_write_t;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_COUNTING,
        WD_EXPIRED
    } wd_state_t;

endpackage

// File: core/bus_activity_watchdog.sv
/*
 * Bus-activity watchdog: times the gap between valid host transactions,
 * forces all fan duty outputs to full on timeout and keeps the period
 * and sticky status fields of global_control.
 * Assumes the bus slave outside gives a one-cycle pulse per valid
 * transaction and a one-cycle register write strobe, and that the PWM
 * logic keeps its own duty values while the override is applied.
 */
`timescale 1ns/1ps

module bus_activity_watchdog
    import bus_watchdog_pkg::*;
#(
    parameter longint unsigned PERIOD_A_CYCLES = PERIOD_A_CYC,
    parameter longint unsigned PERIOD_B_CYCLES = PERIOD_B_CYC,
    parameter longint unsigned PERIOD_C_CYCLES = PERIOD_C_CYC
)
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       clk_en_in,
    input  wire logic       watchdog_default_strap_pin_in,
    input  wire logic       bus_transaction_in,
    input  wire reg_write_t reg_write_in,
    input  wire fan_duty_t  duty_in,
    output logic [7:0]      global_control_out,
    output fan_duty_t       fan_drive_output_out,
    output logic            timeout_active_out
);

    logic [1:0]         period_reg;
    logic [1:0]         period_next;
    logic               status_reg;
    logic               status_next;
    logic               strap_done_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    wd_state_t          state_reg;
    wd_state_t          state_next;

    wire logic               ctrl_write;
    wire logic               status_clear;
    wire logic               enabled;
    wire logic [TIMER_W-1:0] limit;
    wire logic               expire;
    wire logic               forced;
    wire logic [1:0]         strap_period;
    wire logic               timer_at_limit;
    wire logic [TIMER_W-1:0] timer_inc;
    wire fan_duty_t          fan_drive_next;

    // Register decode
    assign ctrl_write   = reg_write_in.wr && (reg_write_in.addr == GLOBAL_CONTROL_OFFSET);
    assign status_clear = ctrl_write && !reg_write_in.wdata[STATUS_BIT];

    // Period selection
    assign enabled = (period_reg != PERIOD_OFF);
    assign limit   = (period_reg == PERIOD_5S)  ? TIMER_W'(PERIOD_A_CYCLES - 1) :
                     (period_reg == PERIOD_10S) ? TIMER_W'(PERIOD_B_CYCLES - 1) :
                                                  TIMER_W'(PERIOD_C_CYCLES - 1);
    // A period change other than to OFF while counting keeps the running count
    assign timer_at_limit = (timer_reg >= limit);
    assign timer_inc      = timer_reg + TIMER_W'(1);
    assign expire         = enabled && (state_reg == WD_COUNTING) && !bus_transaction_in
                            && timer_at_limit;

    // Strap is taken once, on the first enabled edge after reset
    assign strap_period = watchdog_default_strap_pin_in ? PERIOD_STRAP_HIGH
                                                        : PERIOD_STRAP_LOW;

    // Period field: strap first, software afterwards
    always_comb
    begin
        period_next = period_reg;
        if (!strap_done_reg)
        begin
            period_next = strap_period;
        end
        else if (ctrl_write)
        begin
            period_next = reg_write_in.wdata[PERIOD_MSB:PERIOD_LSB];
        end
    end

    // Sticky status, set wins over clear
    always_comb
    begin
        status_next = status_reg;
        if (status_clear)
        begin
            status_next = 1'b0;
        end
        if (expire)
        begin
            status_next = 1'b1;
        end
    end

    // Watchdog state and timer
    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        case (state_reg)
            WD_IDLE:
            begin
                timer_next = '0;
                if (enabled)
                begin
                    state_next = WD_COUNTING;
                end
            end
            WD_COUNTING:
            begin
                if (!enabled)
                begin
                    state_next = WD_IDLE;
                    timer_next = '0;
                end
                else if (bus_transaction_in)
                begin
                    timer_next = '0;
                end
                else if (expire)
                begin
                    state_next = WD_EXPIRED;
                    timer_next = '0;
                end
                else
                begin
                    timer_next = timer_inc;
                end
            end
            WD_EXPIRED:
            begin
                timer_next = '0;
                if (!enabled)
                begin
                    state_next = WD_IDLE;
                end
                else if (bus_transaction_in)
                begin
                    state_next = WD_COUNTING;
                end
            end
            default:
            begin
                state_next = WD_IDLE;
                timer_next = '0;
            end
        endcase
    end

    assign forced = (state_next == WD_EXPIRED);

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            period_reg     <= PERIOD_OFF;
            status_reg     <= STATUS_RESET;
            strap_done_reg <= 1'b0;
            timer_reg      <= '0;
            state_reg      <= WD_IDLE;
        end
        else if (clk_en_in)
        begin
            period_reg     <= period_next;
            status_reg     <= status_next;
            strap_done_reg <= 1'b1;
            timer_reg      <= timer_next;
            state_reg      <= state_next;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            global_control_out <= 8'h00;
            timeout_active_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            global_control_out <= {5'h00, period_next, status_next};
            timeout_active_out <= forced;
        end
    end

    // Per-fan override, live duty passes through otherwise
    genvar i;
    generate
        for (i = 0; i < FAN_COUNT; i++)
        begin : g_fan
            assign fan_drive_next[i] = forced ? FULL_DUTY : duty_in[i];
        end
    endgenerate

    // One flop bank for all channels, so the output has a single driver
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fan_drive_output_out <= '0;
        end
        else if (clk_en_in)
        begin
            fan_drive_output_out <= fan_drive_next;
        end
    end

endmodule

// File: tb/bus_watchdog_sva.sv
/* Checker for the bus-activity watchdog ports.
   Assumes PERIOD_A_CYCLES is below 255; gap tracking pauses with clk_en_in. */
`timescale 1ns/1ps
module bus_watchdog_sva
    import bus_watchdog_pkg::*;
#(
    parameter longint unsigned PERIOD_A_CYCLES = 8
)
(
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    input wire logic       clk_en_in,
    input wire logic       bus_transaction_in,
    input wire reg_write_t reg_write_in,
    input wire fan_duty_t  duty_in,
    input wire logic [7:0] global_control_out,
    input wire fan_duty_t  fan_drive_output_out,
    input wire logic       timeout_active_out
);
    wire logic [1:0] per = global_control_out[2:1];
    wire logic       w00 = clk_en_in && reg_write_in.wr && reg_write_in.addr == 8'h00;
    wire logic [7:0] lim = 8'(PERIOD_A_CYCLES);
    logic [7:0]      gap_reg;
    // Cycles since last transaction, 8'hff once period leaves 01
    wire logic [7:0] gap_next = bus_transaction_in ? 8'h00 :
                                (per != 2'h1 || gap_reg == 8'hff) ? 8'hff : gap_reg + 8'h01;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            gap_reg <= 8'hff;
        else if (clk_en_in)
            gap_reg <= gap_next;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    full_duty_a: assert property (
        timeout_active_out |-> fan_drive_output_out == {FAN_COUNT{FULL_DUTY}})
        else $error("fans not full while timed out");
    expire_time_a: assert property (
        per == 2'h1 && gap_reg <= lim |-> timeout_active_out == (gap_reg == lim))
        else $error("timeout at wrong cycle");
    restore_duty_a: assert property (
        clk_en_in && timeout_active_out && bus_transaction_in |=>
        !timeout_active_out && fan_drive_output_out == $past(duty_in))
        else $error("duty not restored");
    pass_duty_a: assert property (
        $past(rst_n_in) && $past(clk_en_in) && !timeout_active_out |->
        fan_drive_output_out == $past(duty_in))
        else $error("duty not passed");
    status_sticky_a: assert property (
        global_control_out[0] && !(w00 && !reg_write_in.wdata[0]) |=> global_control_out[0])
        else $error("status lost");
    status_set_a: assert property (
        $rose(timeout_active_out) |-> global_control_out[0])
        else $error("status not set");
    period_write_a: assert property (
        $past(rst_n_in) && w00 |=> per == $past(reg_write_in.wdata[2:1]))
        else $error("period not written");
    off_idle_a: assert property (
        per == 2'h0 |=> !timeout_active_out)
        else $error("timeout while off");
    cover property ($rose(timeout_active_out));
    cover property (timeout_active_out && bus_transaction_in);
    cover property ($fell(global_control_out[0]));
    cover property (w00 && !reg_write_in.wdata[0] ##1 $rose(timeout_active_out));
endmodule
bind bus_activity_watchdog bus_watchdog_sva #(.PERIOD_A_CYCLES(PERIOD_A_CYCLES)) chk_u (
    .ref_clk_in, .rst_n_in, .clk_en_in, .bus_transaction_in, .reg_write_in, .duty_in,
    .global_control_out, .fan_drive_output_out, .timeout_active_out);

// File: tb/host_model.sv
/* Host master model: transaction pulses and register writes.
   Assumes callers start just after a rising edge. */
`timescale 1ns/1ps
module host_model
    import bus_watchdog_pkg::*;
(
    input  wire logic ref_clk_in,
    output logic       txn_out,
    output reg_write_t wr_out
);
    initial txn_out = 1'b0;
    initial wr_out = '{1'b0, 8'hff, 8'hff};
    task automatic ping;
        txn_out = 1'b1;
        @(posedge ref_clk_in);
        #1 txn_out = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_out = '{1'b1, a, d};
        @(posedge ref_clk_in);
        #1 wr_out = '{1'b0, ~a, ~d};
    endtask
endmodule

// File: tb/testbench.sv
/* Self-checking bench for the bus-activity watchdog.
   Assumes periods shortened to 8, 16 and 24 cycles. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    import bus_watchdog_pkg::*;
    logic       ref_clk, rst_n, strap, txn, to, en;
    logic [1:0] pv;
    logic [7:0] gc;
    reg_write_t wr;
    fan_duty_t  duty, fan;
    int         bad_count, n_compared, lim;
    host_model host_u (.ref_clk_in(ref_clk), .txn_out(txn), .wr_out(wr));
    bus_activity_watchdog #(.PERIOD_A_CYCLES(8), .PERIOD_B_CYCLES(16), .PERIOD_C_CYCLES(24))
        dut_u (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .clk_en_in(en),
        .watchdog_default_strap_pin_in(strap), .bus_transaction_in(txn), .reg_write_in(wr),
        .duty_in(duty), .global_control_out(gc), .fan_drive_output_out(fan),
        .timeout_active_out(to));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic final_report;
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        #200us;
        bad_count++;
        final_report();
    end
    initial
    begin
        duty = {8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11};
        strap = 1'b1;
        en = 1'b1;
        rst_n = 1'b0;
        step(20);
        rst_n = 1'b1;
        step(2);
        `CHK("strap high", 8'h06, gc)
        for (int p = 1; p < 4; p++)
        begin
            pv = 2'(p);
            lim = p * 8;
            host_u.wr(8'h00, {5'h00, pv, 1'b1});
            `CHK("set ignored", {5'h00, pv, 1'b0}, gc)
            step(1);
            host_u.wr(8'h01, 8'h00);
            `CHK("unmapped", {5'h00, pv, 1'b0}, gc)
            host_u.ping();
            repeat (3)
            begin
                step(lim - 2);
                host_u.ping();
            end
            `CHK("kept alive", 1'b0, to)
            `CHK("no status", {5'h00, pv, 1'b0}, gc)
            step(lim - 1);
            `CHK("not yet", 1'b0, to)
            host_u.wr(8'h00, {5'h00, pv, 1'b0});
            `CHK("full duty", {FAN_COUNT{FULL_DUTY}}, fan)
            `CHK("status set", {5'h00, pv, 1'b1}, gc)
            duty = {6{8'(p * 33)}};
            host_u.ping();
            `CHK("restored", duty, fan)
            `CHK("released", 1'b0, to)
            `CHK("status kept", {5'h00, pv, 1'b1}, gc)
            host_u.wr(8'h00, {5'h00, pv, 1'b0});
            `CHK("status clear", {5'h00, pv, 1'b0}, gc)
            duty = ~duty;
            step(1);
            `CHK("reprogram", duty, fan)
        end
        host_u.ping();
        en = 1'b0;
        step(40);
        `CHK("frozen", 1'b0, to)
        `CHK("frozen reg", 8'h06, gc)
        en = 1'b1;
        step(lim - 1);
        `CHK("resumed", 1'b0, to)
        step(1);
        `CHK("late expiry", 1'b1, to)
        strap = 1'b0;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(2);
        `CHK("strap low", 8'h00, gc)
        step(40);
        `CHK("off idle", 1'b0, to)
        final_report();
    end
endmodule
